// ===== shared/tic_defs.vh
`ifndef TIC_DEFS_VH
`define TIC_DEFS_VH

// Clock rate and time bases
`define TIC_CLK_MHZ        10
`define TIC_NS_PER_US      1000
`define TIC_US_PER_S       1000000

// Register byte addresses
`define TIC_ADDR_W         8
`define TIC_DATA_W         32
`define TIC_A_CTRL         8'h00
`define TIC_A_LOGIC        8'h04
`define TIC_A_DEBOUNCE     8'h08
`define TIC_A_PRESCALE     8'h0c
`define TIC_A_EXPOSURE     8'h10
`define TIC_A_TIMER        8'h14
`define TIC_A_STATUS       8'h18

// Control register fields
`define TIC_CTRL_MODE_EN   0
`define TIC_CTRL_SRC       3:1
`define TIC_CTRL_EXPMODE   5:4
`define TIC_CTRL_DEB_EN    6
`define TIC_CTRL_TE_VAR    7
`define TIC_CTRL_NV_SAVE   8
`define TIC_CTRL_SW_TRIG   9
`define TIC_CTRL_TRIG_EN   10
`define TIC_CTRL_W         11
`define TIC_CTRL_RST       11'h000

// Logic register fields
`define TIC_LOG_SRC_A      1:0
`define TIC_LOG_SRC_B      3:2
`define TIC_LOG_FN1        6:4
`define TIC_LOG_SRC_C      9:8
`define TIC_LOG_FN2        14:12
`define TIC_LOG_CHAIN      16
`define TIC_LOG_OUT_EN     17
`define TIC_LOG_W          18
`define TIC_LOG_RST        18'h00000

// Status register fields
`define TIC_ST_STATE       1:0
`define TIC_ST_EXPOSING    2
`define TIC_ST_TRIG        3
`define TIC_ST_MISSED      15:8

// Trigger sources
`define TIC_SRC_LINE0      3'h0
`define TIC_SRC_LINE1      3'h1
`define TIC_SRC_LINE2      3'h2
`define TIC_SRC_LINE3      3'h3
`define TIC_SRC_LOGIC      3'h4
`define TIC_SRC_SOFT       3'h5
`define TIC_SRC_TIMER      3'h6

// Logic functions
`define TIC_FN_AND         3'h0
`define TIC_FN_NAND        3'h1
`define TIC_FN_OR          3'h2
`define TIC_FN_NOR         3'h3
`define TIC_FN_XOR         3'h4
`define TIC_FN_XNOR        3'h5

// Exposure modes
`define TIC_EXP_PROG       2'h0
`define TIC_EXP_PULSE      2'h1
`define TIC_EXP_SEQ        2'h2

// Widths
`define TIC_DEB_W          20
`define TIC_PRE_W          4
`define TIC_MISS_W         8
`define TIC_LINES          4

// Timing
`define TIC_DEB_HOLD_DEF   66666
`define TIC_EXP_DEF        10000
`define TIC_EXP_MIN_US     60
`define TIC_EXP_MAX_S      60
`define TIC_EXP_MIN_CYC    (`TIC_EXP_MIN_US * `TIC_CLK_MHZ)
`define TIC_EXP_MAX_CYC    (`TIC_EXP_MAX_S * `TIC_US_PER_S * `TIC_CLK_MHZ)
`define TIC_EXP_DELAY_NS   300
`define TIC_EXP_DELAY_CYC  ((`TIC_EXP_DELAY_NS * `TIC_CLK_MHZ + `TIC_NS_PER_US - 1) / `TIC_NS_PER_US)
`define TIC_MIN_PULSE_NS   2000
`define TIC_MIN_PULSE_CYC  ((`TIC_MIN_PULSE_NS * `TIC_CLK_MHZ + `TIC_NS_PER_US - 1) / `TIC_NS_PER_US)

`endif

// ===== rtl/tic_debounce.v
`timescale 1ns/1ps
`include "tic_defs.vh"

module tic_debounce (
   input  wire                  clk_i,      // System clock
   input  wire                  resetn_i,   // Async reset, active low
   input  wire                  enable_i,   // Debouncer in the path
   input  wire [`TIC_DEB_W-1:0] hold_i,     // Hold time in clock ticks
   input  wire                  level_i,    // Raw level, same clock
   output reg                   level_o     // Debounced level
);

   reg  [`TIC_DEB_W-1:0] count_reg;
   wire [`TIC_DEB_W-1:0] count_inc;

   assign count_inc = count_reg + {{(`TIC_DEB_W-1){1'b0}}, 1'b1};

   // A new level passes only after staying stable for the hold time
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count_reg <= {`TIC_DEB_W{1'b0}};
         level_o   <= 1'b0;
      end else if (!enable_i) begin
         count_reg <= {`TIC_DEB_W{1'b0}};
         level_o   <= level_i;
      end else if (level_i == level_o) begin
         count_reg <= {`TIC_DEB_W{1'b0}};  // Bounce back restarts the wait
      end else if (count_inc >= hold_i) begin
         count_reg <= {`TIC_DEB_W{1'b0}};
         level_o   <= level_i;             // Stable long enough
      end else begin
         count_reg <= count_inc;
      end
   end

endmodule // tic_debounce

// ===== rtl/tic_top.v
// Summary of operation
// - Logic stage combines two operands picked from two selectable inputs.
// - Functions AND, NAND, OR, NOR, XOR, XNOR with standard truth tables.
// - Trigger-enable variant uses the trigger enable bit as second operand.
// - Logic result feeds the trigger, a second stage, or an output line.
// - Debouncer passes a level only after it stays stable for the hold time.
// - Debounce hold time counts in system clock ticks.
// - Enabled debouncer sits between selected line and the edge detector.
// - Four-bit prescaler divides trigger pulses by one to sixteen.
// - Capture starts on a software, line, logic or internal timer trigger, or on a sequencer start pulse.
// - After reset the trigger source is the first trigger line.
// - External trigger mode starts exposure on the conditioned rising edge.
// - Programmable mode takes exposure length from a setting, 60 us to 60 s.
// - Trigger during frame valid waits for the next line valid falling edge.
// - Trigger with frame valid low starts after a short fixed delay.
// - Exposure setting may change anytime; frames in progress keep old value.
// - Exposure setting is saved to and restored from nonvolatile storage.
// - Sequencer mode exposes from first sequencer pulse to second one.
`timescale 1ns/1ps
`include "tic_defs.vh"

module tic_top #(
   parameter [`TIC_DEB_W-1:0]  DEB_HOLD_DEFAULT = `TIC_DEB_HOLD_DEF,
   parameter [`TIC_DATA_W-1:0] EXP_DEFAULT      = `TIC_EXP_DEF
) (
   input  wire                   clk_i,                 // System clock, 10 MHz
   input  wire                   resetn_i,              // Async reset, active low
   input  wire [`TIC_ADDR_W-1:0] addr_i,                // Register byte address
   input  wire [`TIC_DATA_W-1:0] wdata_i,               // Write data
   input  wire                   we_i,                  // Write strobe
   input  wire                   re_i,                  // Read strobe
   output reg  [`TIC_DATA_W-1:0] rdata_o,               // Read data, cycle after re_i
   input  wire [`TIC_LINES-1:0]  trigger_line_i,        // Trigger pins, bit 0 first line
   input  wire                   frame_valid_strobe_i,  // Sensor frame valid
   input  wire                   line_valid_strobe_i,   // Sensor line valid
   input  wire                   seq_pulse_start_i,     // Sequencer start pulse
   input  wire                   seq_pulse_stop_i,      // Sequencer stop pulse
   input  wire                   nv_restore_i,          // Restore pulse from storage
   input  wire [`TIC_DATA_W-1:0] nv_exposure_i,         // Stored exposure value
   output reg                    nv_save_o,             // Save pulse to storage
   output reg  [`TIC_DATA_W-1:0] nv_data_o,             // Exposure value to store
   output reg                    exposure_o,            // Sensor exposing
   output reg                    exposure_start_o,      // Exposure start pulse
   output reg                    logic_line_o           // Logic result on output line
);

   // Exposure sequencer states
   localparam [1:0] ST_IDLE   = 2'h0;
   localparam [1:0] ST_WAITLV = 2'h1;
   localparam [1:0] ST_DELAY  = 2'h2;
   localparam [1:0] ST_EXPOSE = 2'h3;

   localparam [`TIC_DATA_W-1:0] EXP_MIN   = `TIC_EXP_MIN_CYC;
   localparam [`TIC_DATA_W-1:0] EXP_MAX   = `TIC_EXP_MAX_CYC;
   localparam [`TIC_DATA_W-1:0] DELAY_CYC = `TIC_EXP_DELAY_CYC;
   localparam [`TIC_DATA_W-1:0] MINPW_CYC = `TIC_MIN_PULSE_CYC;
   localparam [`TIC_DATA_W-1:0] ONE       = 32'h00000001;

   // Boolean function shared by both logic stages
   function logic_op;
      input [2:0] fn;
      input       a;
      input       b;
      begin
         case (fn)
            `TIC_FN_AND:  logic_op = a & b;
            `TIC_FN_NAND: logic_op = ~(a & b);
            `TIC_FN_OR:   logic_op = a | b;
            `TIC_FN_NOR:  logic_op = ~(a | b);
            `TIC_FN_XOR:  logic_op = a ^ b;
            `TIC_FN_XNOR: logic_op = ~(a ^ b);
            default:      logic_op = 1'b0;
         endcase
      end
   endfunction

   // Clamp an exposure value into the legal range
   function [`TIC_DATA_W-1:0] exp_clamp;
      input [`TIC_DATA_W-1:0] v;
      begin
         if (v < EXP_MIN)
            exp_clamp = EXP_MIN;
         else if (v > EXP_MAX)
            exp_clamp = EXP_MAX;
         else
            exp_clamp = v;
      end
   endfunction

   reg  [`TIC_CTRL_W-1:0]  ctrl_reg;
   reg  [`TIC_LOG_W-1:0]   logic_reg;
   reg  [`TIC_DEB_W-1:0]   deb_hold_reg;
   reg  [`TIC_PRE_W-1:0]   prescale_reg;
   reg  [`TIC_DATA_W-1:0]  exp_set_reg;
   reg  [`TIC_DATA_W-1:0]  timer_period_reg;
   reg                     sw_pulse_reg;
   reg  [`TIC_LINES-1:0]   sync1_reg;
   reg  [`TIC_LINES-1:0]   sync2_reg;
   reg  [`TIC_LINES-1:0]   sync3_reg;
   reg  [`TIC_LINES-1:0]   line_reg;
   reg  [`TIC_DATA_W-1:0]  timer_cnt_reg;
   reg                     timer_pulse_reg;
   reg                     deb_prev_reg;
   reg  [`TIC_PRE_W-1:0]   pre_cnt_reg;
   reg                     line_valid_strobe_prev_reg;
   reg  [1:0]              state_reg;
   reg  [1:0]              state_next;
   reg  [`TIC_DATA_W-1:0]  cnt_reg;
   reg  [`TIC_DATA_W-1:0]  cnt_next;
   reg  [`TIC_DATA_W-1:0]  exp_act_reg;
   reg  [`TIC_DATA_W-1:0]  width_reg;
   reg  [`TIC_MISS_W-1:0]  missed_reg;
   reg                     src_level;
   reg                     op_a;
   reg                     op_b;
   reg                     op_c;
   reg                     load_exp;
   wire                    stage1_out;
   wire                    stage2_out;
   wire                    logic_out;
   wire                    is_line_src;
   wire                    deb_level;
   wire                    trig_rise;
   wire                    trig_fwd;
   wire                    line_valid_strobe_fall;
   wire                    start_evt;
   wire                    end_evt;
   wire [1:0]              exp_mode;

   // Line pins pass three flops; a change counts when stages two and three agree
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1_reg <= {`TIC_LINES{1'b0}};
         sync2_reg <= {`TIC_LINES{1'b0}};
         sync3_reg <= {`TIC_LINES{1'b0}};
         line_reg  <= {`TIC_LINES{1'b0}};
      end else begin
         sync1_reg <= trigger_line_i;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         line_reg  <= (sync2_reg & sync3_reg) | (line_reg & (sync2_reg | sync3_reg));
      end
   end

   // Operand selection for both logic stages
   always @* begin
      op_a = line_reg[logic_reg[`TIC_LOG_SRC_A]];
      op_b = line_reg[logic_reg[`TIC_LOG_SRC_B]];
      if (ctrl_reg[`TIC_CTRL_TE_VAR])
         op_b = ctrl_reg[`TIC_CTRL_TRIG_EN];
      op_c = line_reg[logic_reg[`TIC_LOG_SRC_C]];
   end

   assign stage1_out = logic_op(logic_reg[`TIC_LOG_FN1], op_a, op_b);
   // Second stage takes the first result together with another input
   assign stage2_out = logic_op(logic_reg[`TIC_LOG_FN2], stage1_out, op_c);
   assign logic_out  = logic_reg[`TIC_LOG_CHAIN] ? stage2_out : stage1_out;

   // Trigger source mux; software and timer arrive as one-cycle pulses
   always @* begin
      case (ctrl_reg[`TIC_CTRL_SRC])
         `TIC_SRC_LINE0: src_level = line_reg[0];
         `TIC_SRC_LINE1: src_level = line_reg[1];
         `TIC_SRC_LINE2: src_level = line_reg[2];
         `TIC_SRC_LINE3: src_level = line_reg[3];
         `TIC_SRC_LOGIC: src_level = logic_out;
         `TIC_SRC_SOFT:  src_level = sw_pulse_reg;
         `TIC_SRC_TIMER: src_level = timer_pulse_reg;
         default:        src_level = 1'b0;
      endcase
   end

   // Debouncing applies to lines and the logic result; software and timer pulses bypass it
   assign is_line_src = (ctrl_reg[`TIC_CTRL_SRC] <= `TIC_SRC_LOGIC);

   tic_debounce u_debounce (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .enable_i (ctrl_reg[`TIC_CTRL_DEB_EN] & is_line_src),
      .hold_i   (deb_hold_reg),
      .level_i  (src_level),
      .level_o  (deb_level)
   );

   // Edge detector sees only the conditioned level
   assign trig_rise = deb_level & ~deb_prev_reg & ctrl_reg[`TIC_CTRL_MODE_EN];
   assign trig_fwd  = trig_rise & (pre_cnt_reg == prescale_reg);
   assign line_valid_strobe_fall = line_valid_strobe_prev_reg & ~line_valid_strobe_i;
   assign exp_mode  = ctrl_reg[`TIC_CTRL_EXPMODE];

   // Sequencer mode opens on its start pulse, otherwise on the forwarded edge
   assign start_evt = (exp_mode == `TIC_EXP_SEQ) ?
                      (seq_pulse_start_i & ctrl_reg[`TIC_CTRL_MODE_EN]) :
                      trig_fwd;

   // Exposure end condition for each mode
   assign end_evt = (exp_mode == `TIC_EXP_PROG)  ? (cnt_reg <= ONE) :
                    (exp_mode == `TIC_EXP_PULSE) ?
                    (~deb_level & (width_reg >= MINPW_CYC)) :
                    seq_pulse_stop_i;

   // Prescaler counts accepted edges and restarts after forwarding one
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pre_cnt_reg   <= {`TIC_PRE_W{1'b0}};
         deb_prev_reg  <= 1'b0;
         line_valid_strobe_prev_reg <= 1'b0;
      end else begin
         deb_prev_reg  <= deb_level;
         line_valid_strobe_prev_reg <= line_valid_strobe_i;
         if (trig_fwd)
            pre_cnt_reg <= {`TIC_PRE_W{1'b0}};
         else if (trig_rise)
            pre_cnt_reg <= pre_cnt_reg + {{(`TIC_PRE_W-1){1'b0}}, 1'b1};
      end
   end

   // Internal timed trigger; a zero period stops it
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         timer_cnt_reg   <= {`TIC_DATA_W{1'b0}};
         timer_pulse_reg <= 1'b0;
      end else if (timer_period_reg == {`TIC_DATA_W{1'b0}}) begin
         timer_cnt_reg   <= {`TIC_DATA_W{1'b0}};
         timer_pulse_reg <= 1'b0;
      end else if (timer_cnt_reg + ONE >= timer_period_reg) begin
         timer_cnt_reg   <= {`TIC_DATA_W{1'b0}};
         timer_pulse_reg <= 1'b1;
      end else begin
         timer_cnt_reg   <= timer_cnt_reg + ONE;
         timer_pulse_reg <= 1'b0;
      end
   end

   // Exposure sequencer next state
   always @* begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      load_exp   = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (start_evt) begin
               if (frame_valid_strobe_i) begin
                  state_next = ST_WAITLV;
               end else begin
                  state_next = ST_DELAY;
                  cnt_next   = DELAY_CYC;
               end
            end
         end
         ST_WAITLV: begin
            if (line_valid_strobe_fall) begin
               state_next = ST_EXPOSE;
               load_exp   = 1'b1;
            end
         end
         ST_DELAY: begin
            if (cnt_reg <= ONE) begin
               state_next = ST_EXPOSE;
               load_exp   = 1'b1;
            end else begin
               cnt_next = cnt_reg - ONE;
            end
         end
         ST_EXPOSE: begin
            if (end_evt)
               state_next = ST_IDLE;
            else
               cnt_next = cnt_reg - ONE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (load_exp)
         cnt_next = exp_act_reg;
   end

   // Exposure sequencer registers and outputs
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg        <= ST_IDLE;
         cnt_reg          <= {`TIC_DATA_W{1'b0}};
         exp_act_reg      <= EXP_DEFAULT;
         width_reg        <= {`TIC_DATA_W{1'b0}};
         missed_reg       <= {`TIC_MISS_W{1'b0}};
         exposure_o       <= 1'b0;
         exposure_start_o <= 1'b0;
      end else begin
         state_reg        <= state_next;
         cnt_reg          <= cnt_next;
         exposure_start_o <= load_exp;
         exposure_o       <= (state_next == ST_EXPOSE);
         // Setting is sampled only while idle, so a running frame keeps its length
         if (state_reg == ST_IDLE)
            exp_act_reg <= exp_set_reg;
         // Width counts from the trigger acceptance for the minimum pulse width
         if (state_reg == ST_IDLE)
            width_reg <= ONE;
         else if (width_reg != {`TIC_DATA_W{1'b1}})
            width_reg <= width_reg + ONE;
         // Triggers during a busy exposure are dropped and counted
         if (start_evt && state_reg != ST_IDLE && missed_reg != {`TIC_MISS_W{1'b1}})
            missed_reg <= missed_reg + {{(`TIC_MISS_W-1){1'b0}}, 1'b1};
      end
   end

   // Register writes; action bits are pulses and never stored
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_reg         <= `TIC_CTRL_RST;
         logic_reg        <= `TIC_LOG_RST;
         deb_hold_reg     <= DEB_HOLD_DEFAULT;
         prescale_reg     <= {`TIC_PRE_W{1'b0}};
         exp_set_reg      <= EXP_DEFAULT;
         timer_period_reg <= {`TIC_DATA_W{1'b0}};
         sw_pulse_reg     <= 1'b0;
         nv_save_o        <= 1'b0;
         nv_data_o        <= {`TIC_DATA_W{1'b0}};
      end else begin
         sw_pulse_reg <= 1'b0;
         nv_save_o    <= 1'b0;
         if (nv_restore_i)
            exp_set_reg <= exp_clamp(nv_exposure_i);
         if (we_i) begin
            case (addr_i)
               `TIC_A_CTRL: begin
                  ctrl_reg     <= wdata_i[`TIC_CTRL_W-1:0];
                  ctrl_reg[`TIC_CTRL_NV_SAVE] <= 1'b0;
                  ctrl_reg[`TIC_CTRL_SW_TRIG] <= 1'b0;
                  sw_pulse_reg <= wdata_i[`TIC_CTRL_SW_TRIG];
                  nv_save_o    <= wdata_i[`TIC_CTRL_NV_SAVE];
                  nv_data_o    <= exp_set_reg;
               end
               `TIC_A_LOGIC:    logic_reg        <= wdata_i[`TIC_LOG_W-1:0];
               `TIC_A_DEBOUNCE: deb_hold_reg     <= wdata_i[`TIC_DEB_W-1:0];
               `TIC_A_PRESCALE: prescale_reg     <= wdata_i[`TIC_PRE_W-1:0];
               `TIC_A_EXPOSURE: exp_set_reg      <= exp_clamp(wdata_i);
               `TIC_A_TIMER:    timer_period_reg <= wdata_i;
               default: begin
               end
            endcase
         end
      end
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= {`TIC_DATA_W{1'b0}};
      end else begin
         rdata_o <= {`TIC_DATA_W{1'b0}};
         if (re_i) begin
            case (addr_i)
               `TIC_A_CTRL:     rdata_o[`TIC_CTRL_W-1:0] <= ctrl_reg;
               `TIC_A_LOGIC:    rdata_o[`TIC_LOG_W-1:0]  <= logic_reg;
               `TIC_A_DEBOUNCE: rdata_o[`TIC_DEB_W-1:0]  <= deb_hold_reg;
               `TIC_A_PRESCALE: rdata_o[`TIC_PRE_W-1:0]  <= prescale_reg;
               `TIC_A_EXPOSURE: rdata_o                  <= exp_set_reg;
               `TIC_A_TIMER:    rdata_o                  <= timer_period_reg;
               `TIC_A_STATUS: begin
                  rdata_o[`TIC_ST_STATE]    <= state_reg;
                  rdata_o[`TIC_ST_EXPOSING] <= exposure_o;
                  rdata_o[`TIC_ST_TRIG]     <= deb_level;
                  rdata_o[`TIC_ST_MISSED]   <= missed_reg;
               end
               default: rdata_o <= {`TIC_DATA_W{1'b0}};
            endcase
         end
      end
   end

   // Logic result routed to the output line when enabled
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)
         logic_line_o <= 1'b0;
      else
         logic_line_o <= logic_out & logic_reg[`TIC_LOG_OUT_EN];
   end

endmodule // tic_top

// ===== test/tic_checker.sv
`timescale 1ns/1ps
`include "tic_defs.vh"
module tic_checker (
   input wire                   clk_i,             // System clock
   input wire                   resetn_i,          // Reset, active low
   input wire [`TIC_ADDR_W-1:0] addr_i,            // Register address
   input wire [`TIC_DATA_W-1:0] wdata_i,           // Write data
   input wire                   we_i,              // Write strobe
   input wire                   re_i,              // Read strobe
   input wire [`TIC_DATA_W-1:0] rdata_o,           // Read data
   input wire                   frame_valid_strobe_i, // Frame valid
   input wire                   line_valid_strobe_i,  // Line valid
   input wire                   nv_save_o,         // Save pulse
   input wire                   exposure_o,        // Exposing
   input wire                   exposure_start_o   // Start pulse
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   logic [31:0] run_cnt;
   // Cycles of the exposure in progress, zero while idle
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)
         run_cnt <= 32'h0;
      else
         run_cnt <= exposure_o ? run_cnt + 32'h1 : 32'h0;
   end
   // Pulse-width mode as last written; other modes may expose briefly
   logic pulse_md;
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)
         pulse_md <= 1'b0;
      else if (we_i && addr_i == `TIC_A_CTRL)
         pulse_md <= wdata_i[`TIC_CTRL_EXPMODE] == `TIC_EXP_PULSE;
   end
   // Save request on the bus, then a single save pulse
   sequence s_save_req;
      we_i && addr_i == `TIC_A_CTRL && wdata_i[`TIC_CTRL_NV_SAVE];
   endsequence
   sequence s_one_pulse;
      nv_save_o ##1 !nv_save_o;
   endsequence
   AST_RD_IDLE: assert property (!re_i |=> rdata_o == 32'h0)
      else $error("read data outside read cycle");
   AST_RD_UNMAP: assert property (re_i && addr_i == 8'h1c |=> rdata_o == 32'h0)
      else $error("unmapped read not zero");
   AST_START_ONE: assert property (exposure_start_o |=> !exposure_start_o)
      else $error("start pulse too long");
   AST_START_RISE: assert property ($rose(exposure_o) |-> exposure_start_o)
      else $error("exposure without start pulse");
   AST_START_EXP: assert property (exposure_start_o |-> exposure_o && run_cnt == 32'h0)
      else $error("start pulse off first cycle");
   AST_FV_ALIGN: assert property ($rose(exposure_o) && frame_valid_strobe_i |-> !line_valid_strobe_i)
      else $error("start during readout not at line end");
   AST_EXP_MIN: assert property ($fell(exposure_o) && pulse_md |->
      run_cnt >= `TIC_MIN_PULSE_CYC - `TIC_EXP_DELAY_CYC)
      else $error("exposure shorter than minimum");
   AST_NV_SAVE: assert property (s_save_req |=> s_one_pulse)
      else $error("save pulse missing");
endmodule // tic_checker
bind tic_top tic_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .nv_save_o(nv_save_o),
   .frame_valid_strobe_i(frame_valid_strobe_i), .line_valid_strobe_i(line_valid_strobe_i),
   .exposure_o(exposure_o), .exposure_start_o(exposure_start_o));

// ===== test/tic_trig_src.sv
`timescale 1ns/1ps
module tic_trig_src (
   output logic line_o   // Switch contact on the first trigger line
);
   initial line_o = 1'b0;
   // Contact bounce, each spike far shorter than the hold time
   task bounce(input int n);
      repeat (n) begin
         line_o = 1'b1;
         #330 line_o = 1'b0;
         #330;
      end
   endtask
   // Steady level, moved off the clock edge to avoid a sampling race
   task set(input logic lv);
      #10 line_o = lv;
   endtask
endmodule // tic_trig_src

// ===== test/tic_top_tb.sv
`timescale 1ns/1ps
`include "tic_defs.vh"
module tic_top_tb;
   logic        clk_i = 0, resetn_i = 0, we_i = 0, re_i = 0, fv = 0, lv = 0, nv_rs = 0;
   logic [7:0]  addr_i = 0;
   logic [31:0] wdata_i = 0, rdata_o, v, nv_data, nv_x = 0;
   logic [2:0]  hi = 0;
   logic        line0, exp_o, st_o, lg_o, sv_o, sq_a = 0, sq_b = 0;
   int          num_errors = 0, n_tests = 0, n_st = 0, len = 0, n0;
   always #50 clk_i = ~clk_i;
   tic_trig_src src (.line_o(line0));
   tic_top #(.DEB_HOLD_DEFAULT(20'h4), .EXP_DEFAULT(32'h258)) dut (.clk_i(clk_i),
      .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
      .rdata_o(rdata_o), .trigger_line_i({hi, line0}), .frame_valid_strobe_i(fv),
      .line_valid_strobe_i(lv), .seq_pulse_start_i(sq_a), .seq_pulse_stop_i(sq_b),
      .nv_restore_i(nv_rs), .nv_exposure_i(nv_x), .nv_save_o(sv_o), .nv_data_o(nv_data),
      .exposure_o(exp_o), .exposure_start_o(st_o), .logic_line_o(lg_o));
   // Starts seen and length of the latest exposure
   always @(posedge clk_i) begin
      n_st <= n_st + st_o;
      len <= st_o ? 1 : len + exp_o;
   end
   task cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i) begin
         we_i <= 1;
         addr_i <= a;
         wdata_i <= d;
      end
      @(posedge clk_i) we_i <= 0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk_i) begin
         re_i <= 1;
         addr_i <= a;
      end
      @(posedge clk_i) re_i <= 0;
      #1 v = rdata_o;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   // Inversion in bit 0, base function in bits 2:1
   function logic lf(input logic [2:0] fn, input logic a, input logic b);
      lf = (fn[2] ? a ^ b : fn[1] ? a | b : a & b) ^ fn[0];
   endfunction
   task give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Watchdog well beyond the roughly ten and a half thousand cycles the tests need
   initial begin
      #3000000;
      num_errors++;
      give_verdict;
   end
   initial begin
      cyc(2);
      resetn_i <= 1;
      rd(`TIC_A_CTRL); chk(v, 0, "ctrl reset");
      rd(`TIC_A_DEBOUNCE); chk(v, 4, "hold reset");
      rd(8'h1c); chk(v, 0, "unmapped read");
      wr(`TIC_A_EXPOSURE, 5); rd(`TIC_A_EXPOSURE); chk(v, 32'h258, "clamp");
      $display("test registers done");
      for (int f = 0; f < 24; f++) begin
         wr(`TIC_A_LOGIC, 32'h20004 | (f / 4) << 4);
         src.set(f[1]);
         hi[0] <= f[0];
         cyc(8); chk(lg_o, lf(f / 4, f[1], f[0]), "logic");
      end
      hi <= 3'b110;
      wr(`TIC_A_CTRL, 32'h480);
      wr(`TIC_A_LOGIC, 32'h20004);
      cyc(8); chk(lg_o, 1, "enable operand");
      wr(`TIC_A_LOGIC, 32'h34304);
      cyc(8); chk(lg_o, 0, "second stage");
      src.set(0);
      hi <= 0;
      // Let the line level settle low so the next soft pulse is a fresh edge
      cyc(8);
      $display("test logic done");
      wr(`TIC_A_EXPOSURE, 32'h2bc);
      wr(`TIC_A_CTRL, 32'h20b); n0 = n_st;
      cyc(8); chk(n_st - n0, 1, "soft start");
      cyc(750); chk(len, 700, "exposure length");
      wr(`TIC_A_PRESCALE, 2); n0 = n_st;
      repeat (6) begin
         wr(`TIC_A_CTRL, 32'h20b);
         cyc(800);
      end
      chk(n_st - n0, 2, "prescale");
      wr(`TIC_A_PRESCALE, 0);
      fv <= 1;
      lv <= 1;
      wr(`TIC_A_CTRL, 32'h20b); n0 = n_st;
      cyc(20); chk(n_st - n0, 0, "waits for line end");
      lv <= 0;
      cyc(4); chk(n_st - n0, 1, "aligned start");
      fv <= 0;
      cyc(750);
      wr(`TIC_A_TIMER, 1000);
      wr(`TIC_A_CTRL, 32'h0d); n0 = n_st;
      cyc(2100); chk(n_st - n0, 2, "timer starts");
      wr(`TIC_A_TIMER, 0);
      cyc(750);
      $display("test trigger done");
      wr(`TIC_A_DEBOUNCE, 20);
      wr(`TIC_A_CTRL, 32'h41); n0 = n_st;
      src.bounce(3);
      src.set(1);
      cyc(15); chk(n_st - n0, 0, "bounce held back");
      cyc(30); chk(n_st - n0, 1, "stable level");
      src.set(0);
      cyc(750);
      $display("test debounce done");
      wr(`TIC_A_CTRL, 32'h11);
      src.set(1);
      cyc(40);
      src.set(0);
      cyc(20); chk(len, 37, "pulse width");
      src.set(1);
      cyc(5);
      src.set(0);
      cyc(30); chk(len, 17, "minimum width");
      wr(`TIC_A_CTRL, 32'h21);
      sq_a <= 1;
      cyc(1);
      sq_a <= 0;
      cyc(40);
      sq_b <= 1;
      cyc(1);
      sq_b <= 0;
      cyc(3); chk(len, 38, "sequencer window");
      $display("test modes done");
      wr(`TIC_A_CTRL, 32'h100);
      cyc(1); chk(nv_data, 32'h2bc, "saved value");
      chk(sv_o, 1, "save pulse");
      nv_rs <= 1;
      nv_x <= 32'h384;
      cyc(1);
      nv_rs <= 0;
      chk(sv_o, 0, "save pulse ends");
      rd(`TIC_A_EXPOSURE); chk(v, 32'h384, "restored");
      $display("test storage done");
      give_verdict;
   end
endmodule // tic_top_tb
